// ---- hdl/pfa_flash_access.sv ----
// Paged nonvolatile array access: reads, command pipeline, protection
//
// Summary of operation
// - 128 KB array, 1024 rows, 1 KB sectors
// - Byte/aligned word one access, misaligned two
// - Erased bits read one, programmed zero
// - No valid read data while busy
// - Mass and sector erase run automatically
// - Two-stage command pipeline
// - Requests on buffer empty and all done
// - 0x4000-0xFFFF decoded as three windows
// - Middle window page from page select
// - Fixed windows on pages 3E, 3F, 3D
// - Protection can block whole array
// - Lower, higher and remaining protectable areas
// - Lower and higher area bounds
// - Configuration field byte placement
// - Stall CPU while loading settings at reset
// - Protected address aborts, sets violation flag
// - Key access enable gives invalid reads
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pfa_cfg.svh"
module pfa_flash_access import pfa_pkg::*; #(
	parameter int PROG_CYCLES = `PFA_PROG_CYCLES,
	parameter int ERASE_CYCLES = `PFA_ERASE_CYCLES
)(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [15:0] reg_rdata_q,
	// CPU array read port
	input wire logic cpu_rd,
	input wire pfa_rd_req_t cpu_req,
	input wire logic [7:0] program_page_select,
	input wire logic low_map_en,
	output logic cpu_ready_q,
	output logic cpu_rvalid_q,
	output logic [15:0] cpu_rdata_q,
	// Interrupt requests
	output logic irq_buf_empty_q,
	output logic irq_cmd_done_q
);
	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [7:0] cfg_q; // Enables and key access
	logic [7:0] array_protection_reg_q; // Protection setting
	logic [7:0] array_security_reg_q; // Security/options copy
	logic protection_violation_flag_q; // Sticky violation
	logic access_error_q; // Sticky sequence error
	logic seq_addr_q; // Step one done
	logic seq_cmd_q; // Step two done
	logic [15:0] seq_waddr_q; // Word address of step one
	logic [15:0] cdata_q; // Data of step one
	pfa_op_t seq_op_q; // Operation of step two
	logic buf_valid_q; // Pipeline stage one full
	pfa_cmd_t buf_q; // Buffered command
	pfa_cmd_t act_q; // Executing command
	pfa_eng_t eng_q; // Engine state
	logic [23:0] cnt_q; // Operation timer
	logic [15:0] sweep_q; // Current word being written
	logic [15:0] sweep_end_q; // Last word of the operation
	pfa_rd_t rd_q; // Read sequencer
	logic rd_bad_q; // Read result must be invalid
	logic [15:0] rd_next_q; // Second word of misaligned read
	logic rd_odd_q; // Odd byte address
	logic rd_word_q; // Word sized request
	logic [7:0] rd_hi_q; // First byte of misaligned read

	// ----------------------------------------------------------------
	// Decodes
	// ----------------------------------------------------------------
	logic wr_cfg, wr_prot, wr_stat, wr_cmd, wr_caddr, wr_cdata;
	logic cbeif, ccif, eng_busy, loading, launch, eng_take, rd_take;
	logic any_prot, key_acc, rd_inval;
	logic protection_violation_flag_set, accerr_set;
	logic [16:0] c_arr, r_arr;
	logic c_hit, c_prot, r_hit;
	logic mem_en, mem_we;
	logic [15:0] mem_addr, mem_wdata, mem_rdata;

	// Write strobes per register
	assign wr_cfg = reg_we && reg_addr == `PFA_REG_CFG;
	assign wr_prot = reg_we && reg_addr == `PFA_REG_PROT;
	assign wr_stat = reg_we && reg_addr == `PFA_REG_STAT;
	assign wr_cmd = reg_we && reg_addr == `PFA_REG_CMD;
	assign wr_caddr = reg_we && reg_addr == `PFA_REG_CADDR;
	assign wr_cdata = reg_we && reg_addr == `PFA_REG_CDATA;

	// Pipeline status flags
	assign cbeif = !buf_valid_q;
	assign ccif = cbeif && eng_q == ENG_IDLE;
	assign loading = eng_q == ENG_LD_PROT || eng_q == ENG_LD_SEC || eng_q == ENG_LD_DONE;
	assign eng_busy = eng_q != ENG_IDLE;
	assign key_acc = cfg_q[`PFA_CFG_KEY_ACCESS_ENABLE];
	assign any_prot = !array_protection_reg_q[`PFA_PR_OPEN]
		|| !array_protection_reg_q[`PFA_PR_HDIS]
		|| !array_protection_reg_q[`PFA_PR_LDIS];
	// Launch needs both steps, an empty buffer and an unlocked controller
	assign launch = wr_stat && reg_wdata[`PFA_ST_CBEIF] && seq_addr_q && seq_cmd_q
		&& cbeif && !protection_violation_flag_q;
	assign eng_take = eng_q == ENG_IDLE && buf_valid_q;
	assign rd_take = cpu_rd && cpu_ready_q;

	// ----------------------------------------------------------------
	// Address translation: command address and CPU address
	// ----------------------------------------------------------------
	pfa_xlate u_xlate_cmd (
		.log_addr(reg_wdata),
		.page(program_page_select),
		.low_map_en(low_map_en),
		.prot(array_protection_reg_q),
		.arr_addr(c_arr),
		.hit(c_hit),
		.prot_hit(c_prot)
	);

	pfa_xlate u_xlate_rd (
		.log_addr(cpu_req.addr),
		.page(program_page_select),
		.low_map_en(low_map_en),
		.prot(array_protection_reg_q),
		.arr_addr(r_arr),
		.hit(r_hit),
		.prot_hit()
	);

	// ----------------------------------------------------------------
	// Array storage and port sharing
	// ----------------------------------------------------------------
	// Engine owns the port while loading or writing; a CPU read issued
	// then is flagged invalid, so the read path never waits on it.
	always_comb begin
		mem_en = 1'b0;
		mem_we = 1'b0;
		mem_addr = '0;
		mem_wdata = act_q.data;
		case (eng_q)
			ENG_LD_PROT: begin
				mem_en = 1'b1;
				mem_addr = `PFA_PROT_WORD;
			end
			ENG_LD_SEC: begin
				mem_en = 1'b1;
				mem_addr = `PFA_SEC_WORD;
			end
			ENG_WRITE: begin
				mem_en = 1'b1;
				mem_we = 1'b1;
				mem_addr = sweep_q;
				mem_wdata = act_q.op == OP_PROG ? act_q.data : `PFA_ERASED;
			end
			default: begin
				mem_en = rd_take || rd_q == RD_FIRST;
				mem_addr = rd_q == RD_FIRST ? rd_next_q : r_arr[16:1];
			end
		endcase
	end

	pfa_mem #(
		.AW(16),
		.DW(16)
	) u_mem (
		.clk(clk),
		.nrst(nrst),
		.en(mem_en),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata_q(mem_rdata)
	);

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	// Configuration: interrupt enables, key access
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= `PFA_CFG_RST;
		end else if (wr_cfg) begin
			cfg_q <= {reg_wdata[7:5], 5'h00};
		end
	end

	// Protection: loaded from the field at reset, then software writable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			array_protection_reg_q <= `PFA_PROT_RST;
		end else if (eng_q == ENG_LD_SEC) begin
			array_protection_reg_q <= mem_rdata[15:8];
		end else if (wr_prot && !loading) begin
			array_protection_reg_q <= reg_wdata[7:0];
		end
	end

	// Security byte: read only copy of the field
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			array_security_reg_q <= `PFA_SEC_RST;
		end else if (eng_q == ENG_LD_DONE) begin
			array_security_reg_q <= mem_rdata[15:8];
		end
	end

	// Command data of step one
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cdata_q <= '0;
		end else if (wr_cdata) begin
			cdata_q <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Command sequence checker
	// ----------------------------------------------------------------
	// Protected address or mass erase under protection aborts
	assign protection_violation_flag_set = !protection_violation_flag_q
		&& ((wr_caddr && cbeif && c_hit && c_prot)
		|| (wr_cmd && seq_addr_q && reg_wdata[6:0] == `PFA_CMD_MERASE && any_prot));
	// Steps out of order, unknown command or launch without steps
	assign accerr_set = !protection_violation_flag_q
		&& ((wr_caddr && (!cbeif || !c_hit))
		|| (wr_cmd && (!seq_addr_q || (reg_wdata[6:0] != `PFA_CMD_PROG
			&& reg_wdata[6:0] != `PFA_CMD_SERASE && reg_wdata[6:0] != `PFA_CMD_MERASE)))
		|| (wr_stat && reg_wdata[`PFA_ST_CBEIF] && !launch));

	// Step tracking; a violation or launch restarts the sequence
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seq_addr_q <= 1'b0;
			seq_cmd_q <= 1'b0;
			seq_waddr_q <= '0;
			seq_op_q <= OP_PROG;
		end else if (protection_violation_flag_set || accerr_set || launch) begin
			seq_addr_q <= 1'b0;
			seq_cmd_q <= 1'b0;
		end else if (wr_caddr && !protection_violation_flag_q) begin
			seq_addr_q <= 1'b1;
			seq_cmd_q <= 1'b0;
			seq_waddr_q <= c_arr[16:1];
		end else if (wr_cmd && !protection_violation_flag_q) begin
			seq_cmd_q <= 1'b1;
			case (reg_wdata[6:0])
				`PFA_CMD_SERASE: seq_op_q <= OP_SERASE;
				`PFA_CMD_MERASE: seq_op_q <= OP_MERASE;
				default: seq_op_q <= OP_PROG;
			endcase
		end
	end

	// Sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			protection_violation_flag_q <= 1'b0;
			access_error_q <= 1'b0;
		end else begin
			protection_violation_flag_q <= protection_violation_flag_set || (protection_violation_flag_q
				&& !(wr_stat && reg_wdata[`PFA_ST_PROTECTION_VIOLATION_FLAG]));
			access_error_q <= accerr_set
				|| (access_error_q && !(wr_stat && reg_wdata[`PFA_ST_ACCERR]));
		end
	end

	// ----------------------------------------------------------------
	// Command pipeline: buffer stage
	// ----------------------------------------------------------------
	// Launch only when empty, take only when full, so they never collide
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			buf_valid_q <= 1'b0;
			buf_q <= '0;
		end else if (launch) begin
			buf_valid_q <= 1'b1;
			buf_q <= '{op: seq_op_q, waddr: seq_waddr_q, data: cdata_q};
		end else if (eng_take) begin
			buf_valid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Command engine: reset load, timed wait, word sweep
	// ----------------------------------------------------------------
	// The whole erase waits its time once, then writes one word per
	// cycle; real cells would be erased in one pulse.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			eng_q <= ENG_LD_PROT;
			act_q <= '0;
			cnt_q <= '0;
			sweep_q <= '0;
			sweep_end_q <= '0;
		end else begin
			case (eng_q)
				ENG_LD_PROT: eng_q <= ENG_LD_SEC;
				ENG_LD_SEC: eng_q <= ENG_LD_DONE;
				ENG_LD_DONE: eng_q <= ENG_IDLE;
				ENG_IDLE: begin
					if (eng_take) begin
						act_q <= buf_q;
						eng_q <= ENG_WAIT;
						case (buf_q.op)
							OP_PROG: begin
								cnt_q <= 24'(PROG_CYCLES - 1);
								sweep_q <= buf_q.waddr;
								sweep_end_q <= buf_q.waddr;
							end
							OP_SERASE: begin
								cnt_q <= 24'(ERASE_CYCLES - 1);
								sweep_q <= buf_q.waddr & ~16'(`PFA_SECTOR_WORDS - 1);
								sweep_end_q <= buf_q.waddr | 16'(`PFA_SECTOR_WORDS - 1);
							end
							default: begin
								cnt_q <= 24'(ERASE_CYCLES - 1);
								sweep_q <= '0;
								sweep_end_q <= 16'(`PFA_WORDS - 1);
							end
						endcase
					end
				end
				ENG_WAIT: begin
					if (cnt_q == '0) begin
						eng_q <= ENG_WRITE;
					end else begin
						cnt_q <= cnt_q - 24'h00_0001;
					end
				end
				ENG_WRITE: begin
					if (sweep_q == sweep_end_q) begin
						eng_q <= ENG_IDLE;
					end else begin
						sweep_q <= sweep_q + 16'h0001;
					end
				end
				default: eng_q <= ENG_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// CPU read sequencer
	// ----------------------------------------------------------------
	// Invalid when unmapped, engine busy or key access enabled
	assign rd_inval = !r_hit || eng_busy || key_acc;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_q <= RD_IDLE;
			rd_bad_q <= 1'b0;
			rd_next_q <= '0;
			rd_odd_q <= 1'b0;
			rd_word_q <= 1'b0;
			rd_hi_q <= '0;
		end else begin
			case (rd_q)
				RD_IDLE: begin
					if (rd_take) begin
						rd_q <= RD_FIRST;
						rd_bad_q <= rd_inval;
						rd_odd_q <= r_arr[0];
						rd_word_q <= cpu_req.word;
						rd_next_q <= r_arr[16:1] + 16'h0001;
					end
				end
				RD_FIRST: begin
					if (rd_word_q && rd_odd_q) begin
						rd_q <= RD_SECOND;
						rd_hi_q <= mem_rdata[15:8];
						rd_bad_q <= rd_bad_q || eng_busy || key_acc;
					end else begin
						rd_q <= RD_IDLE;
					end
				end
				default: rd_q <= RD_IDLE;
			endcase
		end
	end

	// Result register; one access for byte or aligned word
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cpu_rvalid_q <= 1'b0;
			cpu_rdata_q <= '0;
		end else begin
			cpu_rvalid_q <= (rd_q == RD_FIRST && !(rd_word_q && rd_odd_q))
				|| rd_q == RD_SECOND;
			if (rd_q == RD_FIRST && !(rd_word_q && rd_odd_q)) begin
				if (rd_bad_q) begin
					cpu_rdata_q <= `PFA_INVALID_DATA;
				end else if (rd_word_q) begin
					cpu_rdata_q <= {mem_rdata[7:0], mem_rdata[15:8]};
				end else begin
					cpu_rdata_q <= {8'h00, rd_odd_q ? mem_rdata[15:8] : mem_rdata[7:0]};
				end
			end else if (rd_q == RD_SECOND) begin
				cpu_rdata_q <= rd_bad_q ? `PFA_INVALID_DATA
					: {rd_hi_q, mem_rdata[7:0]};
			end
		end
	end

	// Ready: low while loading settings or a read is in flight
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cpu_ready_q <= 1'b0;
		end else begin
			cpu_ready_q <= !loading && !rd_take
				&& (rd_q == RD_IDLE || (rd_q == RD_FIRST && !(rd_word_q && rd_odd_q))
				|| rd_q == RD_SECOND);
		end
	end

	// ----------------------------------------------------------------
	// Interrupt requests and register read back
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_buf_empty_q <= 1'b0;
			irq_cmd_done_q <= 1'b0;
		end else begin
			irq_buf_empty_q <= cfg_q[`PFA_CFG_BEIE] && cbeif && !loading;
			irq_cmd_done_q <= cfg_q[`PFA_CFG_CCIE] && ccif;
		end
	end

	// Read data in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q <= '0;
		end else if (reg_re) begin
			case (reg_addr)
				`PFA_REG_CFG: reg_rdata_q <= {8'h00, cfg_q};
				`PFA_REG_SEC: reg_rdata_q <= {8'h00, array_security_reg_q};
				`PFA_REG_PROT: reg_rdata_q <= {8'h00, array_protection_reg_q};
				`PFA_REG_STAT: reg_rdata_q <= {8'h00, cbeif, ccif,
					protection_violation_flag_q, access_error_q, 4'h0};
				`PFA_REG_CMD: reg_rdata_q <= {14'h0000, seq_op_q};
				`PFA_REG_CADDR: reg_rdata_q <= seq_waddr_q;
				`PFA_REG_CDATA: reg_rdata_q <= cdata_q;
				default: reg_rdata_q <= '0;
			endcase
		end else begin
			reg_rdata_q <= '0;
		end
	end
endmodule : pfa_flash_access
`default_nettype wire

// ---- hdl/pfa_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the array access block
`ifndef PFA_CFG_SVH
`define PFA_CFG_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define PFA_REG_CFG 8'h00
`define PFA_REG_SEC 8'h04
`define PFA_REG_PROT 8'h08
`define PFA_REG_STAT 8'h0C
`define PFA_REG_CMD 8'h10
`define PFA_REG_CADDR 8'h14
`define PFA_REG_CDATA 8'h18
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PFA_CFG_BEIE 7
`define PFA_CFG_CCIE 6
`define PFA_CFG_KEY_ACCESS_ENABLE 5
`define PFA_ST_CBEIF 7
`define PFA_ST_CCIF 6
`define PFA_ST_PROTECTION_VIOLATION_FLAG 5
`define PFA_ST_ACCERR 4
`define PFA_PR_OPEN 7
`define PFA_PR_HDIS 5
`define PFA_PR_HS 4:3
`define PFA_PR_LDIS 2
`define PFA_PR_LS 1:0
// ----------------------------------------------------------------
// Reset values, commands, data patterns
// ----------------------------------------------------------------
`define PFA_CFG_RST 8'h00
`define PFA_PROT_RST 8'hFF
`define PFA_SEC_RST 8'hFF
`define PFA_CMD_PROG 7'h20
`define PFA_CMD_SERASE 7'h40
`define PFA_CMD_MERASE 7'h41
`define PFA_ERASED 16'hFFFF
`define PFA_INVALID_DATA 16'h0000
// ----------------------------------------------------------------
// Array geometry, windows and protection regions
// ----------------------------------------------------------------
`define PFA_ROWS 1024
`define PFA_ROW_BYTES 128
`define PFA_SECTOR_ROWS 8
`define PFA_SECTOR_WORDS (`PFA_SECTOR_ROWS * `PFA_ROW_BYTES / 2)
`define PFA_WORDS (`PFA_ROWS * `PFA_ROW_BYTES / 2)
`define PFA_PAGE_LOW 8'h3D
`define PFA_PAGE_FIX0 8'h3E
`define PFA_PAGE_FIX1 8'h3F
`define PFA_LOW_BASE 18'h1_8000
`define PFA_LOW_MIN 18'h0_0400
`define PFA_ARRAY_TOP 18'h2_0000
`define PFA_HIGH_MIN 18'h0_0800
`define PFA_PROT_WORD 16'hFF86
`define PFA_SEC_WORD 16'hFF87
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PFA_CLK_NS 4
`define PFA_PROG_NS 20000
`define PFA_ERASE_NS 20000000
`define PFA_PROG_CYCLES ((`PFA_PROG_NS + `PFA_CLK_NS - 1) / `PFA_CLK_NS)
`define PFA_ERASE_CYCLES ((`PFA_ERASE_NS + `PFA_CLK_NS - 1) / `PFA_CLK_NS)
`endif

// ---- hdl/pfa_pkg.sv ----
// Types shared by the array access block
`default_nettype none
package pfa_pkg;
	// Operation held in a command stage
	typedef enum logic [1:0] {OP_PROG, OP_SERASE, OP_MERASE} pfa_op_t;
	// One command stage: operation, word address, data
	typedef struct packed {
		pfa_op_t op;
		logic [15:0] waddr;
		logic [15:0] data;
	} pfa_cmd_t;
	// CPU read request: logical address and word size
	typedef struct packed {
		logic [15:0] addr;
		logic word;
	} pfa_rd_req_t;
	// Command engine states
	typedef enum logic [2:0] {ENG_LD_PROT, ENG_LD_SEC, ENG_LD_DONE, ENG_IDLE, ENG_WAIT,
		ENG_WRITE} pfa_eng_t;
	// CPU read sequencer states
	typedef enum logic [1:0] {RD_IDLE, RD_FIRST, RD_SECOND} pfa_rd_t;
endpackage : pfa_pkg
`default_nettype wire

// ---- hdl/pfa_mem.sv ----
// Word-wide array storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module pfa_mem #(
	parameter int AW = 16,
	parameter int DW = 16
)(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Access port
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata_q
);
	// Storage cells; low byte is the even byte address. The array starts
	// erased; a declaration value keeps the write port the only writer.
	logic [DW-1:0] cells [0:(1<<AW)-1] = '{default: '1};

	// Write port
	always_ff @(posedge clk) begin
		if (en && we) begin
			cells[addr] <= wdata;
		end
	end

	// Read data register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (en && !we) begin
			rdata_q <= cells[addr];
		end
	end
endmodule : pfa_mem
`default_nettype wire

// ---- hdl/pfa_xlate.sv ----
// Logical to array address translation and protection region check
`timescale 1ns/10ps
`default_nettype none
`include "pfa_cfg.svh"
module pfa_xlate import pfa_pkg::*; (
	// Logical side
	input wire logic [15:0] log_addr,
	input wire logic [7:0] page,
	input wire logic low_map_en,
	// Protection setting
	input wire logic [7:0] prot,
	// Results
	output logic [16:0] arr_addr,
	output logic hit,
	output logic prot_hit
);
	// ----------------------------------------------------------------
	// Window decode
	// ----------------------------------------------------------------
	logic [7:0] sel_page;
	logic [17:0] a18;
	logic [17:0] low_size;
	logic [17:0] high_size;

	// Pick the page for each 16 Kbyte window
	always_comb begin
		hit = 1'b1;
		case (log_addr[15:14])
			2'b00: begin
				sel_page = `PFA_PAGE_LOW;
				hit = low_map_en;
			end
			2'b01: sel_page = `PFA_PAGE_FIX0;
			2'b10: sel_page = page;
			default: sel_page = `PFA_PAGE_FIX1;
		endcase
	end

	// Page low bits above the window offset
	assign arr_addr = {sel_page[2:0], log_addr[13:0]};
	assign a18 = {1'b0, arr_addr};

	// ----------------------------------------------------------------
	// Protection regions
	// ----------------------------------------------------------------
	// Lower area grows up, higher area grows down
	assign low_size = `PFA_LOW_MIN << prot[`PFA_PR_LS];
	assign high_size = `PFA_HIGH_MIN << prot[`PFA_PR_HS];
	assign prot_hit = !prot[`PFA_PR_OPEN]
		|| (!prot[`PFA_PR_LDIS] && a18 >= `PFA_LOW_BASE
			&& a18 < `PFA_LOW_BASE + low_size)
		|| (!prot[`PFA_PR_HDIS] && a18 >= `PFA_ARRAY_TOP - high_size);
endmodule : pfa_xlate
`default_nettype wire

// ---- verif/pfa_cpu_bfm.sv ----
// CPU-side read requester for the array access block
`timescale 1ns/10ps
`default_nettype none
module pfa_cpu_bfm import pfa_pkg::*; (
	// Clock and command
	input wire logic clk,
	input wire logic go,
	input wire pfa_rd_req_t req,
	// Handshake
	input wire logic cpu_ready_q,
	output logic cpu_rd,
	output pfa_rd_req_t cpu_req
);
	// Hold request until taken; scramble address once released
	always @(posedge clk) begin
		if (go) begin
			cpu_rd <= 1'b1;
			cpu_req <= req;
		end else if (cpu_rd && cpu_ready_q) begin
			cpu_rd <= 1'b0;
			cpu_req <= ~cpu_req;
		end
	end
	initial cpu_rd = 1'b0;
	initial cpu_req = '0;
endmodule : pfa_cpu_bfm
`default_nettype wire

// ---- verif/pfa_fa_sva.sv ----
// Port-level assertions for the array access block
`timescale 1ns/10ps
`default_nettype none
module pfa_fa_sva import pfa_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// CPU read port
	input wire logic cpu_rd,
	input wire pfa_rd_req_t cpu_req,
	input wire logic low_map_en,
	input wire logic cpu_ready_q,
	input wire logic cpu_rvalid_q,
	input wire logic [15:0] cpu_rdata_q,
	// Interrupt request
	input wire logic irq_buf_empty_q
);
	logic [2:0] load_q; // Cycles since reset, stops at 4
	logic take; // Read accepted this edge
	logic one_acc; // Byte or aligned word
	assign take = cpu_rd && cpu_ready_q;
	assign one_acc = !cpu_req.word || !cpu_req.addr[0];
	// Count the settings load window
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			load_q <= 3'h0;
		end else if (load_q < 3'h4) begin
			load_q <= load_q + 3'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Misaligned word: two quiet cycles, then the result
	sequence two_acc_s;
		!cpu_rvalid_q [*2] ##1 cpu_rvalid_q;
	endsequence
	rd_short_a: assert property (take && one_acc |-> ##1 !cpu_rvalid_q ##1 cpu_rvalid_q)
		else $error("short read latency wrong");
	rd_long_a: assert property (take && !one_acc |=> two_acc_s)
		else $error("misaligned read latency wrong");
	busy_drop_a: assert property (take |=> !cpu_ready_q)
		else $error("ready stayed high after take");
	ready_back_a: assert property (cpu_rvalid_q |-> cpu_ready_q)
		else $error("ready low with result");
	pulse_one_a: assert property (cpu_rvalid_q |=> !cpu_rvalid_q)
		else $error("result pulse too long");
	hold_data_a: assert property (!cpu_rvalid_q |-> $stable(cpu_rdata_q))
		else $error("read data moved without result");
	load_quiet_a: assert property (load_q < 3'h4 |-> !cpu_ready_q && !irq_buf_empty_q)
		else $error("CPU not stalled during load");
	unmapped_a: assert property (take && cpu_req.addr[15:14] == 2'h0 && !low_map_en
		|-> ##2 cpu_rdata_q == 16'h0000)
		else $error("unmapped read gave data");
endmodule : pfa_fa_sva
bind pfa_flash_access pfa_fa_sva i_pfa_fa_sva(.clk(clk), .nrst(nrst), .cpu_rd(cpu_rd),
	.cpu_req(cpu_req), .low_map_en(low_map_en), .cpu_ready_q(cpu_ready_q),
	.cpu_rvalid_q(cpu_rvalid_q), .cpu_rdata_q(cpu_rdata_q), .irq_buf_empty_q(irq_buf_empty_q));
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the array access block
`timescale 1ns/10ps
`default_nettype none
`include "pfa_cfg.svh"
module testbench;
	logic clk, nrst, reg_we, reg_re, cpu_rd, low_map_en, cpu_ready_q, cpu_rvalid_q, go;
	logic irq_buf_empty_q, irq_cmd_done_q;
	logic [7:0] reg_addr, program_page_select;
	logic [15:0] reg_wdata, reg_rdata_q, cpu_rdata_q;
	pfa_pkg::pfa_rd_req_t cpu_req, req;
	int miscompares, num_checks;
	// Short program and erase counts keep the run brief
	pfa_flash_access #(.PROG_CYCLES(4), .ERASE_CYCLES(8)) i_pfa_flash_access(.clk(clk),
		.nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata_q(reg_rdata_q), .cpu_rd(cpu_rd), .cpu_req(cpu_req),
		.program_page_select(program_page_select), .low_map_en(low_map_en),
		.cpu_ready_q(cpu_ready_q), .cpu_rvalid_q(cpu_rvalid_q), .cpu_rdata_q(cpu_rdata_q),
		.irq_buf_empty_q(irq_buf_empty_q), .irq_cmd_done_q(irq_cmd_done_q));
	pfa_cpu_bfm i_pfa_cpu_bfm(.clk(clk), .go(go), .req(req), .cpu_ready_q(cpu_ready_q),
		.cpu_rd(cpu_rd), .cpu_req(cpu_req));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask : wr
	task automatic rr(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		@(negedge clk);
		chk(reg_rdata_q, e);
	endtask : rr
	// Read through the CPU model, wait for the result pulse
	task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] e);
		int i;
		@(posedge clk);
		go <= 1'b1;
		req <= '{addr: a, word: w};
		@(posedge clk);
		go <= 1'b0;
		for (i = 0; i < 20 && cpu_rvalid_q !== 1'b1; i++) @(negedge clk);
		chk({15'h0000, cpu_rvalid_q}, 16'h0001);
		chk(cpu_rdata_q, e);
	endtask : rd
	// Three-step program sequence, then poll for completion
	task automatic pg(input logic [7:0] p, input logic [15:0] a, input logic [15:0] d);
		int i;
		@(posedge clk) program_page_select <= p;
		wr(`PFA_REG_CDATA, d);
		wr(`PFA_REG_CADDR, a);
		wr(`PFA_REG_CMD, 16'h0020);
		wr(`PFA_REG_STAT, 16'h0080);
		rd(a, 1'b1, 16'h0000);
		for (i = 0; i < 40 && irq_cmd_done_q !== 1'b1; i++) @(negedge clk);
		chk({15'h0000, irq_cmd_done_q}, 16'h0001);
	endtask : pg
	task automatic t_reset;
		repeat (4) @(negedge clk);
		chk({15'h0000, cpu_ready_q}, 16'h0000);
		@(negedge clk);
		chk({15'h0000, cpu_ready_q}, 16'h0001);
		rr(`PFA_REG_PROT, 16'h00FF);
		rr(`PFA_REG_SEC, 16'h00FF);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_read;
		wr(`PFA_REG_CFG, 16'h00C0);
		rr(`PFA_REG_CFG, 16'h00C0);
		chk({15'h0000, irq_buf_empty_q}, 16'h0001);
		rd(16'h4000, 1'b1, 16'hFFFF);
		rd(16'h0000, 1'b1, 16'h0000);
		@(posedge clk) low_map_en <= 1'b1;
		rd(16'h0000, 1'b1, 16'hFFFF);
		@(posedge clk) low_map_en <= 1'b0;
		wr(`PFA_REG_CFG, 16'h00E0);
		rd(16'hC000, 1'b1, 16'h0000);
		wr(`PFA_REG_CFG, 16'h00C0);
		$display("t_read done");
	endtask : t_read
	task automatic t_prog;
		pg(8'h38, 16'h8002, 16'h1234);
		rd(16'h8002, 1'b1, 16'h3412);
		rd(16'h8001, 1'b1, 16'hFF34);
		@(posedge clk) program_page_select <= 8'h39;
		rd(16'h8002, 1'b1, 16'hFFFF);
		pg(8'h39, 16'h4010, 16'h5678);
		@(posedge clk) program_page_select <= 8'h3E;
		rd(16'h8010, 1'b1, 16'h7856);
		// Sector erase of array sector 0, then wait out the word sweep
		@(posedge clk) program_page_select <= 8'h38;
		wr(`PFA_REG_CADDR, 16'h8000);
		wr(`PFA_REG_CMD, 16'h0040);
		wr(`PFA_REG_STAT, 16'h0080);
		repeat (600) @(negedge clk);
		rd(16'h8002, 1'b1, 16'hFFFF);
		rd(16'h4010, 1'b1, 16'h7856);
		$display("t_prog done");
	endtask : t_prog
	task automatic t_prot;
		wr(`PFA_REG_PROT, 16'h007F);
		rr(`PFA_REG_PROT, 16'h007F);
		wr(`PFA_REG_CADDR, 16'h8000);
		rr(`PFA_REG_STAT, 16'h00E0);
		wr(`PFA_REG_STAT, 16'h0020);
		rr(`PFA_REG_STAT, 16'h00C0);
		wr(`PFA_REG_PROT, 16'h00A0);
		wr(`PFA_REG_CADDR, 16'h4400);
		rr(`PFA_REG_STAT, 16'h00C0);
		wr(`PFA_REG_CADDR, 16'h43FE);
		rr(`PFA_REG_STAT, 16'h00E0);
		$display("t_prot done");
	endtask : t_prot
	// Watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#20000;
		miscompares++;
		close_out();
	end
	initial begin
		{nrst, reg_we, reg_re, go, low_map_en} = 5'h0;
		{reg_addr, reg_wdata, req} = '0;
		program_page_select = 8'h38;
		miscompares = 0;
		num_checks = 0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_read();
		t_prog();
		t_prot();
		close_out();
	end
endmodule : testbench
`default_nettype wire
